// File: design/rivsc_ctrl.sv
/*
  Reset source tracking, interrupt vectoring and stack pointer for a small
  8-bit core. Assumes the core drives i/o requests, stack operations and
  interrupt acceptance on clk, and stalls while entry_busy is high.
*/
// Behaviour
// - eight-bit stack pointer at i/o 0x3D
// - push byte minus one, call/irq minus two
// - pop byte plus one, returns plus two
// - irq needs own enable and global enable
// - vectors: reset 0x000, ext 0x001, ovf 0x002
// - lowest vector served first
// - watchdog pulse one cycle, then delay timer
// - low reset pin causes external reset
// - cause register bits seven to two zero
// - pin reset sets external flag
// - power-on sets power-on flag only
// - status register not saved on entry
// - two eight-bit interrupt mask registers
// - accept clears global enable, irq return sets
// - vectoring clears the served source flag
// - flags stay pending until enabled
`timescale 1ns/1ns
module rivsc_ctrl #(
  parameter int RESET_DELAY_CYCLES = 16
) (
  input  wire logic                         clk,
  input  wire logic                         srst,
  input  wire logic                         reset_pin_n,
  input  wire logic                         wdt_timeout,
  input  wire logic                         external_irq_zero,
  input  wire logic                         timer_overflow_irq,
  input  wire rivsc_pkg::rivsc_io_req_type  io_req,
  output      logic [7:0]                   io_rdata,
  input  wire rivsc_pkg::rivsc_stack_op_type stack_op,
  input  wire logic [9:0]                   return_addr,
  input  wire logic                         irq_take,
  output      logic                         irq_pending,
  output      logic                         entry_busy,
  output      rivsc_pkg::rivsc_mem_wr_type  mem_wr,
  output      logic                         pc_load,
  output      logic [9:0]                   pc_vector,
  output      logic                         core_rst,
  output      logic [7:0]                   sp_out
);
  import rivsc_pkg::*;

  logic                  pin_meta_reg, pin_meta_next;
  logic                  pin_sync_reg, pin_sync_next;
  logic [3:0]            pin_cnt_reg, pin_cnt_next;
  logic                  wdt_pulse_reg, wdt_pulse_next;
  logic [15:0]           delay_reg, delay_next;
  logic                  rst_d_reg, rst_d_next;
  logic                  pin_rst, rst_src, blk_rst, accept;
  logic                  ext_ok, ovf_ok;
  logic [DW-1:0]         sp_reg, sp_next;
  logic                  por_flag_reg, por_flag_next;
  logic                  ext_rflag_reg, ext_rflag_next;
  logic [DW-1:0]         gmask_reg, gmask_next;
  logic [DW-1:0]         tmask_reg, tmask_next;
  logic                  gie_reg, gie_next;
  logic                  ext_pend_reg, ext_pend_next;
  logic                  ovf_pend_reg, ovf_pend_next;
  logic                  sel_ext_reg, sel_ext_next;
  logic [PCW-1:0]        ret_reg, ret_next;
  logic [DW-1:0]         rdata_reg, rdata_next;
  rivsc_entry_state_type state_reg, state_next;

  always_comb begin
    pin_meta_next = reset_pin_n;
    pin_sync_next = pin_meta_reg;
    if (pin_sync_reg) begin
      pin_cnt_next = 4'h0;
    end else if (pin_cnt_reg == PIN_MIN_CYCLES) begin
      pin_cnt_next = pin_cnt_reg;
    end else begin
      pin_cnt_next = pin_cnt_reg + 4'h1;
    end
    wdt_pulse_next = wdt_timeout & ~wdt_pulse_reg;
    // delay starts after the pulse ends
    if (rst_src) begin
      delay_next = 16'(RESET_DELAY_CYCLES);
    end else if (delay_reg != 16'h0000) begin
      delay_next = delay_reg - 16'h0001;
    end else begin
      delay_next = delay_reg;
    end
    rst_d_next = core_rst;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_meta_reg  <= 1'b1;
      pin_sync_reg  <= 1'b1;
      pin_cnt_reg   <= 4'h0;
      wdt_pulse_reg <= 1'b0;
      delay_reg     <= 16'(RESET_DELAY_CYCLES);
      rst_d_reg     <= 1'b1;
    end else begin
      pin_meta_reg  <= pin_meta_next;
      pin_sync_reg  <= pin_sync_next;
      pin_cnt_reg   <= pin_cnt_next;
      wdt_pulse_reg <= wdt_pulse_next;
      delay_reg     <= delay_next;
      rst_d_reg     <= rst_d_next;
    end
  end

  assign pin_rst  = (pin_cnt_reg == PIN_MIN_CYCLES);
  assign rst_src  = srst | pin_rst | wdt_pulse_reg;
  assign blk_rst  = pin_rst | wdt_pulse_reg;
  assign core_rst = rst_src | (delay_reg != 16'h0000);

  assign ext_ok      = ext_pend_reg & gmask_reg[EXT_EN_BIT];
  assign ovf_ok      = ovf_pend_reg & tmask_reg[OVF_EN_BIT];
  // pending flags wait for the global enable
  assign irq_pending = gie_reg & (ext_ok | ovf_ok) & ~core_rst & (state_reg == ST_IDLE);
  assign accept      = irq_pending & irq_take;
  assign entry_busy  = (state_reg != ST_IDLE);

  always_comb begin
    sp_next        = sp_reg;
    por_flag_next  = por_flag_reg;
    ext_rflag_next = ext_rflag_reg;
    gmask_next     = gmask_reg;
    tmask_next     = tmask_reg;
    gie_next       = gie_reg;
    ext_pend_next  = ext_pend_reg;
    ovf_pend_next  = ovf_pend_reg;
    sel_ext_next   = sel_ext_reg;
    ret_next       = ret_reg;
    state_next     = state_reg;
    rdata_next     = rdata_reg;
    case (state_reg)
      ST_IDLE: begin
        if (accept) begin
          sel_ext_next = ext_ok;
          ret_next     = return_addr;
          gie_next     = 1'b0;
          state_next   = ST_PUSH_LO;
        end
      end
      ST_PUSH_LO: begin
        sp_next    = sp_reg - 8'h01;
        state_next = ST_PUSH_HI;
      end
      ST_PUSH_HI: begin
        sp_next    = sp_reg - 8'h01;
        state_next = ST_VECTOR;
      end
      ST_VECTOR: begin
        if (sel_ext_reg) begin
          ext_pend_next = 1'b0;
        end else begin
          ovf_pend_next = 1'b0;
        end
        state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
    if (state_reg == ST_IDLE) begin
      case (stack_op)
        SOP_PUSH: sp_next = sp_reg - 8'h01;
        SOP_CALL: sp_next = sp_reg - 8'h02;
        SOP_POP:  sp_next = sp_reg + 8'h01;
        SOP_RET:  sp_next = sp_reg + 8'h02;
        SOP_RETURN_FROM_IRQ_INSTR: begin
          sp_next  = sp_reg + 8'h02;
          gie_next = 1'b1;
        end
        default: sp_next = sp_reg;
      endcase
    end
    if (io_req.we) begin
      case (io_req.addr)
        // software access to the stack pointer
        SP_ADDR:     sp_next = io_req.wdata;
        // only the global enable lives here
        STATUS_ADDR: gie_next = io_req.wdata[GIE_BIT];
        GMASK_ADDR:  gmask_next = io_req.wdata & GMASK_RW_MASK;
        TMASK_ADDR:  tmask_next = io_req.wdata;
        // cause writes store low two bits
        CAUSE_ADDR: begin
          por_flag_next  = io_req.wdata[POR_FLAG_BIT];
          ext_rflag_next = io_req.wdata[EXT_FLAG_BIT];
        end
        default: ;
      endcase
    end
    // pin reset sets external flag, set wins
    if (pin_rst) begin
      ext_rflag_next = 1'b1;
    end
    // events latch, set wins over clear
    if (external_irq_zero) begin
      ext_pend_next = 1'b1;
    end
    if (timer_overflow_irq) begin
      ovf_pend_next = 1'b1;
    end
    if (io_req.re) begin
      case (io_req.addr)
        SP_ADDR:     rdata_next = sp_reg;
        STATUS_ADDR: rdata_next = {gie_reg, 7'h00};
        GMASK_ADDR:  rdata_next = gmask_reg;
        TMASK_ADDR:  rdata_next = tmask_reg;
        CAUSE_ADDR:  rdata_next = {6'h00, ext_rflag_reg, por_flag_reg} & CAUSE_WR_MASK;
        default:     rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst | blk_rst) begin
      sp_reg       <= SP_RST;
      gmask_reg    <= MASK_RST;
      tmask_reg    <= MASK_RST;
      gie_reg      <= 1'b0;
      ext_pend_reg <= 1'b0;
      ovf_pend_reg <= 1'b0;
      sel_ext_reg  <= 1'b0;
      ret_reg      <= VEC_RESET;
      state_reg    <= ST_IDLE;
      rdata_reg    <= 8'h00;
    end else begin
      sp_reg       <= sp_next;
      gmask_reg    <= gmask_next;
      tmask_reg    <= tmask_next;
      gie_reg      <= gie_next;
      ext_pend_reg <= ext_pend_next;
      ovf_pend_reg <= ovf_pend_next;
      sel_ext_reg  <= sel_ext_next;
      ret_reg      <= ret_next;
      state_reg    <= state_next;
      rdata_reg    <= rdata_next;
    end
  end

  // power-on sets flag; other resets keep it
  always_ff @(posedge clk) begin
    if (srst) begin
      por_flag_reg  <= 1'b1;
      ext_rflag_reg <= 1'b0;
    end else begin
      por_flag_reg  <= por_flag_next;
      ext_rflag_reg <= ext_rflag_next;
    end
  end

  assign io_rdata = rdata_reg;
  assign sp_out   = sp_reg;

  // stack writes during entry; low byte first
  always_comb begin
    mem_wr.we   = (state_reg == ST_PUSH_LO) | (state_reg == ST_PUSH_HI);
    mem_wr.addr = sp_reg;
    if (state_reg == ST_PUSH_HI) begin
      mem_wr.data = {6'h00, ret_reg[PCW-1:DW]};
    end else begin
      mem_wr.data = ret_reg[DW-1:0];
    end
  end

  // reset vector on release, irq vector after pushes
  assign pc_load   = (state_reg == ST_VECTOR) | (rst_d_reg & ~core_rst);
  assign pc_vector = (state_reg != ST_VECTOR) ? VEC_RESET :
                     (sel_ext_reg ? VEC_EXT : VEC_OVF);

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence entry_push_s;
    mem_wr.we && mem_wr.addr == $past(sp_reg) ##1 mem_wr.we;
  endsequence
  sequence entry_vec_s;
    pc_load && pc_vector != VEC_RESET;
  endsequence

  sp_push_a: assert property (
    stack_op == SOP_PUSH && !entry_busy && !io_req.we && !blk_rst
    |=> sp_reg == $past(sp_reg) - 8'h01) else $error("push step wrong");
  sp_call_a: assert property (
    stack_op == SOP_CALL && !entry_busy && !io_req.we && !blk_rst
    |=> sp_reg == $past(sp_reg) - 8'h02) else $error("call step wrong");
  sp_ret_a: assert property (
    stack_op == SOP_RET && !entry_busy && !io_req.we && !blk_rst
    |=> sp_reg == $past(sp_reg) + 8'h02) else $error("return step wrong");
  irq_gate_a: assert property (
    irq_pending |-> gie_reg && (ext_ok || ovf_ok))
    else $error("irq without enables");
  entry_seq_a: assert property (
    accept && !blk_rst && !pin_rst
    |=> entry_push_s ##1 entry_vec_s) else $error("entry sequence broken");
  irq_prio_a: assert property (
    accept && ext_ok && !blk_rst
    |=> ##2 pc_vector == VEC_EXT) else $error("priority wrong");
  wdt_pulse_a: assert property (
    wdt_pulse_reg |=> !wdt_pulse_reg && core_rst)
    else $error("watchdog pulse too long");
  cause_rsvd_a: assert property (
    io_req.re && io_req.addr == CAUSE_ADDR && !blk_rst
    |=> io_rdata == {6'h00, $past(ext_rflag_reg), $past(por_flag_reg)})
    else $error("cause read wrong");
  ext_flag_a: assert property (
    pin_rst |=> ext_rflag_reg)
    else $error("external flag not set");
  gie_clr_a: assert property (
    accept && !blk_rst && stack_op != SOP_RETURN_FROM_IRQ_INSTR && !io_req.we
    |=> !gie_reg) else $error("global enable kept");
  flag_clear_a: assert property (
    state_reg == ST_VECTOR && sel_ext_reg && !external_irq_zero && !blk_rst
    |=> !ext_pend_reg) else $error("served flag kept");
endmodule : rivsc_ctrl

// File: design/rivsc_pkg.sv
/*
  Shared constants and types for the reset, interrupt vector and stack pointer
  controller. Assumes an 8-bit core with a 6-bit I/O address space and a
  10-bit program counter.
*/
package rivsc_pkg;
  localparam int IO_AW = 6;
  localparam int DW    = 8;
  localparam int PCW   = 10;

  // i/o space offsets
  localparam logic [IO_AW-1:0] SP_ADDR     = 6'h3D;
  localparam logic [IO_AW-1:0] STATUS_ADDR = 6'h3F;
  localparam logic [IO_AW-1:0] GMASK_ADDR  = 6'h3B;
  localparam logic [IO_AW-1:0] TMASK_ADDR  = 6'h39;
  localparam logic [IO_AW-1:0] CAUSE_ADDR  = 6'h34;

  // field positions and masks
  localparam int             POR_FLAG_BIT  = 0;
  localparam int             EXT_FLAG_BIT  = 1;
  localparam int             GIE_BIT       = 7;
  localparam int             EXT_EN_BIT    = 6;
  localparam int             OVF_EN_BIT    = 1;
  localparam logic [DW-1:0]  CAUSE_WR_MASK = 8'h03;
  localparam logic [DW-1:0]  GMASK_RW_MASK = 8'h40;

  // reset values
  localparam logic [DW-1:0]  SP_RST    = 8'h00;
  localparam logic [DW-1:0]  MASK_RST  = 8'h00;

  // vectors
  localparam logic [PCW-1:0] VEC_RESET = 10'h000;
  localparam logic [PCW-1:0] VEC_EXT   = 10'h001;
  localparam logic [PCW-1:0] VEC_OVF   = 10'h002;

  // timing
  localparam int             CLK_PERIOD_NS    = 50;
  localparam int             PIN_MIN_PULSE_NS = 50;
  localparam logic [3:0]     PIN_MIN_CYCLES   =
    4'((PIN_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    SOP_NONE, SOP_PUSH, SOP_POP, SOP_CALL, SOP_RET, SOP_RETURN_FROM_IRQ_INSTR
  } rivsc_stack_op_type;

  typedef enum logic [1:0] {
    ST_IDLE, ST_PUSH_LO, ST_PUSH_HI, ST_VECTOR
  } rivsc_entry_state_type;

  typedef struct packed {
    logic            we;
    logic            re;
    logic [IO_AW-1:0] addr;
    logic [DW-1:0]   wdata;
  } rivsc_io_req_type;

  typedef struct packed {
    logic          we;
    logic [DW-1:0] addr;
    logic [DW-1:0] data;
  } rivsc_mem_wr_type;
endpackage : rivsc_pkg

// File: tb/rivsc_core_model.sv
/*
  Core-side stack memory model: stores every byte that the controller pushes.
  Assumes mem_wr is sampled on the rising edge of clk.
*/
`timescale 1ns/1ns
module rivsc_core_model (
  input wire logic                        clk,
  input wire rivsc_pkg::rivsc_mem_wr_type mem_wr
);
  import rivsc_pkg::*;
  logic [7:0] mem [256];
  always_ff @(posedge clk) begin
    if (mem_wr.we) begin
      mem[mem_wr.addr] <= mem_wr.data;
    end
  end
endmodule : rivsc_core_model

// File: tb/reset_irq_vector_stack_ctrl_tb.sv
/*
  Self-checking bench for the reset, vector and stack controller.
  Assumes rivsc_pkg and rivsc_ctrl are compiled first; inputs move on negedge.
*/
`timescale 1ns/1ns
module reset_irq_vector_stack_ctrl_tb;
  import rivsc_pkg::*;
  logic               clk, srst, reset_pin_n, wdt_timeout, ext_irq, ovf_irq, irq_take;
  logic               irq_pending, entry_busy, pc_load, core_rst;
  logic [9:0]         return_addr, pc_vector;
  logic [7:0]         io_rdata, sp_out;
  rivsc_io_req_type   io_req;
  rivsc_stack_op_type stack_op;
  rivsc_mem_wr_type   mem_wr;
  int                 errors, compares;

  rivsc_ctrl #(.RESET_DELAY_CYCLES(2)) u_dut (
    .clk(clk), .srst(srst), .reset_pin_n(reset_pin_n), .wdt_timeout(wdt_timeout),
    .external_irq_zero(ext_irq), .timer_overflow_irq(ovf_irq), .io_req(io_req),
    .io_rdata(io_rdata), .stack_op(stack_op), .return_addr(return_addr),
    .irq_take(irq_take), .irq_pending(irq_pending), .entry_busy(entry_busy),
    .mem_wr(mem_wr), .pc_load(pc_load), .pc_vector(pc_vector), .core_rst(core_rst),
    .sp_out(sp_out));
  rivsc_core_model u_core (.clk(clk), .mem_wr(mem_wr));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic tally_and_finish;
    if (errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    io_req = '{1'b1, 1'b0, a, d};
    @(negedge clk);
    io_req = '0;
  endtask : io_wr

  task automatic io_rd(input logic [5:0] a, input logic [7:0] exp, input string msg);
    @(negedge clk);
    io_req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk);
    io_req = '0;
    chk(io_rdata, exp, msg);
  endtask : io_rd

  task automatic op(input rivsc_stack_op_type s);
    @(negedge clk);
    stack_op = s;
    @(negedge clk);
    stack_op = SOP_NONE;
  endtask : op

  task automatic bail(input string msg);
    errors++;
    $display("[ERR] %0t %s timed out", $time, msg);
    tally_and_finish();
  endtask : bail

  task automatic wait_boot;
    int n;
    n = 0;
    @(negedge clk);
    while (core_rst !== 1'b0 && n < 60) begin
      @(negedge clk);
      n++;
    end
    if (core_rst !== 1'b0) bail("boot");
    chk(pc_load, 1, "boot load");
    chk(pc_vector, VEC_RESET, "boot vector");
  endtask : wait_boot

  task automatic take_irq(input logic [9:0] vec);
    int n;
    n = 0;
    @(negedge clk);
    irq_take = 1'b1;
    do begin
      @(negedge clk);
      n++;
    end while (pc_load !== 1'b1 && n < 10);
    irq_take = 1'b0;
    if (pc_load !== 1'b1) bail("entry");
    chk(pc_vector, vec, "irq vector");
    chk(entry_busy, 1, "entry busy");
    @(negedge clk);
    chk(entry_busy, 0, "entry done");
  endtask : take_irq

  task automatic sc_stack;
    io_rd(CAUSE_ADDR, 8'h01, "por cause");
    chk(sp_out, SP_RST, "sp reset");
    io_wr(SP_ADDR, 8'hDF);
    chk(sp_out, 8'hDF, "sp write");
    op(SOP_PUSH);
    chk(sp_out, 8'hDE, "push");
    op(SOP_CALL);
    chk(sp_out, 8'hDC, "call");
    op(SOP_POP);
    chk(sp_out, 8'hDD, "pop");
    op(SOP_RET);
    io_rd(SP_ADDR, 8'hDF, "ret");
  endtask : sc_stack

  task automatic sc_irq;
    @(negedge clk);
    ext_irq = 1'b1;
    ovf_irq = 1'b1;
    @(negedge clk);
    ext_irq = 1'b0;
    ovf_irq = 1'b0;
    chk(irq_pending, 0, "masked pending");
    io_wr(GMASK_ADDR, 8'h40);
    io_wr(TMASK_ADDR, 8'h02);
    chk(irq_pending, 0, "gie clear");
    io_rd(TMASK_ADDR, 8'h02, "tmask");
    io_wr(STATUS_ADDR, 8'h80);
    chk(irq_pending, 1, "gie set");
    take_irq(VEC_EXT);
    chk(u_core.mem[8'hDF], 8'hA5, "ret lo");
    chk(u_core.mem[8'hDE], 8'h02, "ret hi");
    chk(sp_out, 8'hDD, "entry sp");
    io_rd(STATUS_ADDR, 8'h00, "gie cleared");
    op(SOP_RETURN_FROM_IRQ_INSTR);
    chk(sp_out, 8'hDF, "return_from_irq_instr sp");
    chk(irq_pending, 1, "return_from_irq_instr gie");
    take_irq(VEC_OVF);
    op(SOP_RETURN_FROM_IRQ_INSTR);
    chk(irq_pending, 0, "flags cleared");
  endtask : sc_irq

  task automatic sc_resets;
    io_wr(SP_ADDR, 8'hDF);
    @(negedge clk);
    reset_pin_n = 1'b0;
    repeat (4) @(negedge clk);
    reset_pin_n = 1'b1;
    chk(core_rst, 1, "pin reset");
    wait_boot();
    chk(sp_out, SP_RST, "pin sp");
    io_rd(CAUSE_ADDR, 8'h03, "pin cause");
    io_wr(CAUSE_ADDR, 8'hFE);
    io_rd(CAUSE_ADDR, 8'h02, "cause write");
    io_wr(CAUSE_ADDR, 8'h00);
    io_rd(CAUSE_ADDR, 8'h00, "cause clear");
    // flags set so that a watchdog reset that touched them shows
    io_wr(CAUSE_ADDR, 8'h03);
    io_wr(SP_ADDR, 8'hDF);
    @(negedge clk);
    wdt_timeout = 1'b1;
    @(negedge clk);
    wdt_timeout = 1'b0;
    @(negedge clk);
    chk(core_rst, 1, "wdt reset");
    wait_boot();
    chk(sp_out, SP_RST, "wdt sp");
    io_rd(CAUSE_ADDR, 8'h03, "wdt cause");
  endtask : sc_resets

  initial begin
    srst        = 1'b1;
    reset_pin_n = 1'b1;
    wdt_timeout = 1'b0;
    ext_irq     = 1'b0;
    ovf_irq     = 1'b0;
    irq_take    = 1'b0;
    io_req      = '0;
    stack_op    = SOP_NONE;
    return_addr = 10'h2A5;
    errors      = 0;
    compares    = 0;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    wait_boot();
    sc_stack();
    sc_irq();
    sc_resets();
    tally_and_finish();
  end
endmodule : reset_irq_vector_stack_ctrl_tb
